// ===== rtl/assd_core.sv
// serial status flags, ninth bits and data buffer behind an axi4-lite slave
//
// Behaviour
// - 9-bit mode: received ninth bit stored together with the eight data bits
// - 8-bit mode: received ninth-bit position copies received data bit 7
// - 9-bit mode: transmit ninth bit goes to the shifter with the data byte
// - four error enables gate overrun, noise, framing, parity; reset clears all four
// - tx empty sets on shifter load, reset sets; status read then data write clears
// - tx complete: empty and nothing shifting; clears when queued; reset sets
// - rx full sets on buffer load; status read then data read clears
// - idle sets after 10 or 11 one-bit times; cleared by status-data reads
// - idle needs a received character since enable or since idle was last set
// - character arriving with buffer full sets overrun, buffer kept
// - overrun clears on data read only if seen set at status read
// - noise flag set on detected noise, read-sequence clear, gated interrupt
// - framing flag set on zero stop bit, read-sequence clear, gated interrupt
// - parity flag set on parity mismatch, read-sequence clear, gated interrupt
// - break sets break, framing and rx full, clears ninth bit in 9-bit mode
// - break flag cleared by status2-then-data read; rearms only after ones
// - reception flag sets on zero in first sample slot, clears on false start or idle
// - one data address: reads return rx data, writes go to tx data
// - reset leaves data buffers and both ninth bits unchanged
// - character length bit selects 8-bit or 9-bit characters
// - global enable low forces tx empty and tx complete set
`timescale 1ns/1ns
`default_nettype none
module assd_core (
   input  wire logic                  mclk_i,
   input  wire logic                  rstn_i,
   // axi4-lite slave
   input  wire logic [assd_pkg::AW-1:0] s_awaddr_i,
   input  wire logic                  s_awvalid_i,
   output logic                       s_awready_o,
   input  wire logic [31:0]           s_wdata_i,
   input  wire logic [3:0]            s_wstrb_i,
   input  wire logic                  s_wvalid_i,
   output logic                       s_wready_o,
   output logic [1:0]                 s_bresp_o,
   output logic                       s_bvalid_o,
   input  wire logic                  s_bready_i,
   input  wire logic [assd_pkg::AW-1:0] s_araddr_i,
   input  wire logic                  s_arvalid_i,
   output logic                       s_arready_o,
   output logic [31:0]                s_rdata_o,
   output logic [1:0]                 s_rresp_o,
   output logic                       s_rvalid_o,
   input  wire logic                  s_rready_i,
   // receive pin and receiver shift logic
   input  wire logic                  rxd_i,
   input  wire logic                  bit_tick_i,
   input  wire logic                  rx_done_i,
   input  wire logic [8:0]            rx_word_i,
   input  wire logic                  rx_noise_i,
   input  wire logic                  rx_frame_i,
   input  wire logic                  rx_parity_i,
   input  wire logic                  rx_break_i,
   input  wire logic                  rx_slot_zero_i,
   input  wire logic                  rx_false_start_i,
   // transmit shifter
   input  wire logic                  tx_ready_i,
   input  wire logic                  tx_busy_i,
   output logic                       tx_load_o,
   output logic [8:0]                 tx_word_o,
   // interrupt request levels
   output logic                       tx_irq_o,
   output logic                       rx_irq_o,
   output logic                       err_irq_o
);
   import assd_pkg::*;

   function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] o);
      hit = (a[AW-1:2] == o[AW-1:2]);
   endfunction : hit

   logic [7:0] ctrl;
   logic [3:0] errie;
   logic       tx_ninth, rx_ninth;
   logic [7:0] tx_buf, rx_buf;
   logic       tx_empty, tx_complete, rx_full, idle, overrun;
   logic       noise, framing, parity, brk, rx_in_progress_flag;
   logic       brk_armed, idle_armed;
   logic [7:0] snap1;
   logic       snap_brk;
   logic       rxd_meta, rxd_s;
   logic [3:0] ones_cnt;
   logic       wr_go, rd_go, dat_rd, dat_wr, idle_hit;
   logic [7:0] stat1, stat2, rd_mux;
   logic       rd_ok;

   wire en   = ctrl[CT_ENABLE];
   wire nine = ctrl[CT_NINE];

   // rx pin synchroniser; only rxd_s is used by logic
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rxd_meta <= 1'b1;
         rxd_s    <= 1'b1;
      end else begin
         rxd_meta <= rxd_i;
         rxd_s    <= rxd_meta;
      end
   end

   // write accepted only with address and data both present
   assign wr_go       = s_awvalid_i & s_wvalid_i & ~s_bvalid_o;
   assign s_awready_o = wr_go;
   assign s_wready_o  = wr_go;
   assign rd_go       = s_arvalid_i & ~s_rvalid_o;
   assign s_arready_o = rd_go;
   assign dat_rd = rd_go & hit(s_araddr_i, OFS_DATA);
   assign dat_wr = wr_go & s_wstrb_i[0] & hit(s_awaddr_i, OFS_DATA);

   // write response; unmapped addresses answer slverr
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_bvalid_o <= 1'b0;
         s_bresp_o  <= RESP_OKAY;
      end else if (wr_go) begin
         s_bvalid_o <= 1'b1;
         s_bresp_o  <= (hit(s_awaddr_i, OFS_CTRL) | hit(s_awaddr_i, OFS_NINTH)
                       | hit(s_awaddr_i, OFS_STAT1) | hit(s_awaddr_i, OFS_STAT2)
                       | hit(s_awaddr_i, OFS_DATA)) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bready_i) begin
         s_bvalid_o <= 1'b0;
      end
   end

   // control and error enables; writes to status registers are ignored
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl  <= CTRL_RST;
         errie <= ERRIE_RST;
      end else if (wr_go && s_wstrb_i[0]) begin
         if (hit(s_awaddr_i, OFS_CTRL))
            ctrl <= s_wdata_i[7:0];
         if (hit(s_awaddr_i, OFS_NINTH))
            errie <= s_wdata_i[3:0];
      end
   end

   // data buffers and ninth bits hold their contents across reset
   always_ff @(posedge mclk_i) begin
      if (wr_go && s_wstrb_i[0] && hit(s_awaddr_i, OFS_NINTH))
         tx_ninth <= s_wdata_i[NB_TX8];
      if (dat_wr)
         tx_buf <= s_wdata_i[7:0];
      if (rx_break_i && !rx_full) begin
         rx_buf <= 8'h00;
         if (nine)
            rx_ninth <= 1'b0;
      end else if (rx_done_i && !rx_full) begin
         rx_buf   <= rx_word_i[7:0];
         rx_ninth <= nine ? rx_word_i[8] : rx_word_i[7];
      end
   end

   // transmit hand-off: shifter takes buffer and ninth bit together
   assign tx_load_o = ~tx_empty & tx_ready_i & en;
   assign tx_word_o = {nine & tx_ninth, tx_buf};

   // tx empty: shifter load sets, status read then data write clears
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i)
         tx_empty <= 1'b1;
      else if (!en || tx_load_o)
         tx_empty <= 1'b1;
      else if (dat_wr && snap1[S1_TE])
         tx_empty <= 1'b0;
   end

   // tx complete tracks an idle shifter with nothing queued
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i)
         tx_complete <= 1'b1;
      else if (!en)
         tx_complete <= 1'b1;
      else if (tx_busy_i || tx_load_o || (dat_wr && snap1[S1_TE]))
         tx_complete <= 1'b0;
      else if (tx_empty)
         tx_complete <= 1'b1;
   end

   // idle run counter in bit times; threshold follows character length
   assign idle_hit = bit_tick_i && rxd_s && (ones_cnt + 4'h1 == (nine ? IDLE_BITS9 : IDLE_BITS8));
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i)
         ones_cnt <= 4'h0;
      else if (!rxd_s || !ctrl[CT_RXEN])
         ones_cnt <= 4'h0;
      else if (bit_tick_i && !idle_hit)
         ones_cnt <= ones_cnt + 4'h1;
      else if (idle_hit)
         ones_cnt <= 4'h0;
   end

   // receive flags: hardware set wins over the clearing data read
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_full <= 1'b0;
         overrun <= 1'b0;
         noise   <= 1'b0;
         framing <= 1'b0;
         parity  <= 1'b0;
      end else begin
         if (rx_done_i || rx_break_i)
            rx_full <= 1'b1;
         else if (dat_rd && snap1[S1_RF])
            rx_full <= 1'b0;
         if ((rx_done_i || rx_break_i) && rx_full)
            overrun <= 1'b1;
         else if (dat_rd && snap1[S1_OR])
            overrun <= 1'b0;
         if (rx_done_i && !rx_full && rx_noise_i)
            noise <= 1'b1;
         else if (dat_rd && snap1[S1_NF])
            noise <= 1'b0;
         if ((rx_done_i && !rx_full && rx_frame_i) || rx_break_i)
            framing <= 1'b1;
         else if (dat_rd && snap1[S1_FE])
            framing <= 1'b0;
         if (rx_done_i && !rx_full && rx_parity_i)
            parity <= 1'b1;
         else if (dat_rd && snap1[S1_PE])
            parity <= 1'b0;
      end
   end

   // idle flag and its arming by a received character
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         idle       <= 1'b0;
         idle_armed <= 1'b0;
      end else begin
         if (idle_hit && idle_armed)
            idle <= 1'b1;
         else if (dat_rd && snap1[S1_IDLE])
            idle <= 1'b0;
         if ((rx_done_i && !rx_full) || rx_break_i)
            idle_armed <= 1'b1;
         else if (!ctrl[CT_RXEN] || (idle_hit && idle_armed))
            idle_armed <= 1'b0;
      end
   end

   // break flag rearms only once the line has returned to ones
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         brk       <= 1'b0;
         brk_armed <= 1'b1;
      end else begin
         if (rx_break_i && brk_armed)
            brk <= 1'b1;
         else if (dat_rd && snap_brk)
            brk <= 1'b0;
         if (rx_break_i)
            brk_armed <= 1'b0;
         else if (rxd_s)
            brk_armed <= 1'b1;
      end
   end

   // reception in progress; a false start outranks a fresh slot zero
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i)
         rx_in_progress_flag <= 1'b0;
      else if (rx_false_start_i || idle_hit)
         rx_in_progress_flag <= 1'b0;
      else if (rx_slot_zero_i)
         rx_in_progress_flag <= 1'b1;
   end

   assign stat1 = {tx_empty, tx_complete, rx_full, idle, overrun, noise, framing, parity};
   assign stat2 = {6'h00, brk, rx_in_progress_flag};

   // status-read snapshots arm the later data access
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         snap1    <= 8'h00;
         snap_brk <= 1'b0;
      end else begin
         if (rd_go && hit(s_araddr_i, OFS_STAT1))
            snap1 <= stat1;
         else if (dat_rd)
            snap1 <= {snap1[7], 7'h00};
         else if (dat_wr)
            snap1[S1_TE] <= 1'b0;
         if (rd_go && hit(s_araddr_i, OFS_STAT2))
            snap_brk <= brk;
         else if (dat_rd)
            snap_brk <= 1'b0;
      end
   end

   // read mux; rx data and tx data never share storage
   always_comb begin
      rd_mux = 8'h00;
      rd_ok  = 1'b1;
      if (hit(s_araddr_i, OFS_CTRL))
         rd_mux = ctrl;
      else if (hit(s_araddr_i, OFS_NINTH))
         rd_mux = {rx_ninth, tx_ninth, 2'b00, errie};
      else if (hit(s_araddr_i, OFS_STAT1))
         rd_mux = stat1;
      else if (hit(s_araddr_i, OFS_STAT2))
         rd_mux = stat2;
      else if (hit(s_araddr_i, OFS_DATA))
         rd_mux = rx_buf;
      else
         rd_ok = 1'b0;
   end

   // read data registered at address acceptance
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_rvalid_o <= 1'b0;
         s_rdata_o  <= 32'h0000_0000;
         s_rresp_o  <= RESP_OKAY;
      end else if (rd_go) begin
         s_rvalid_o <= 1'b1;
         s_rdata_o  <= {24'h000000, rd_mux};
         s_rresp_o  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_rready_i) begin
         s_rvalid_o <= 1'b0;
      end
   end

   // interrupt levels; break and reception flags never request
   assign tx_irq_o  = en & ((tx_empty & ctrl[CT_TEIE]) | (tx_complete & ctrl[CT_TX_COMPLETE_IRQ_EN]));
   assign rx_irq_o  = rx_full & ctrl[CT_RFIE];
   assign err_irq_o = (overrun & errie[NB_OVERRUN_IRQ_EN]) | (noise & errie[NB_NOISE_IRQ_EN])
                    | (framing & errie[NB_FRAMING_IRQ_EN]) | (parity & errie[NB_PARITY_IRQ_EN])
                    | (idle & ctrl[CT_IDLE_IRQ_EN]);

   // checks
   chk_ovr_keeps_buf: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      rx_done_i && rx_full |=> overrun && rx_buf == $past(rx_buf))
      else $error("overrun altered buffer");
   chk_ninth_copy_b7: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      rx_done_i && !rx_break_i && !rx_full && !nine |=> rx_ninth == $past(rx_word_i[7]))
      else $error("8-bit ninth copy wrong");
   chk_ninth_9bit: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      rx_done_i && !rx_break_i && !rx_full && nine |=> rx_ninth == $past(rx_word_i[8]))
      else $error("9-bit ninth capture wrong");
   chk_tx_ninth_load: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      tx_load_o && nine |-> tx_word_o[8] == tx_ninth)
      else $error("tx ninth bit not loaded");
   chk_empty_on_load: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      tx_load_o |=> tx_empty ##1 tx_empty || $past(dat_wr))
      else $error("tx empty not set after load");
   chk_disable_forces: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      !en |=> tx_empty && tx_complete)
      else $error("disable did not force tx flags");
   chk_break_sets: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      rx_break_i |=> framing && rx_full)
      else $error("break did not set framing and full");
   chk_idle_needs_arm: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      $rose(idle) |-> $past(idle_armed))
      else $error("idle set without character");
   chk_ovr_clear_gate: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      overrun && dat_rd && !snap1[S1_OR] |=> overrun)
      else $error("overrun cleared without status read");
   chk_err_gate: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      errie == 4'h0 && !(idle && ctrl[CT_IDLE_IRQ_EN]) |-> !err_irq_o)
      else $error("error request with enables off");
   cov_overrun: cover property (@(posedge mclk_i) disable iff (!rstn_i) $rose(overrun));
   cov_break: cover property (@(posedge mclk_i) disable iff (!rstn_i) $rose(brk));
   cov_idle: cover property (@(posedge mclk_i) disable iff (!rstn_i) $rose(idle));
   cov_tx_load: cover property (@(posedge mclk_i) disable iff (!rstn_i) tx_load_o);
endmodule : assd_core
`default_nettype wire

// ===== rtl/assd_pkg.sv
// package: register map, field positions and constants of the serial status block
package assd_pkg;
   localparam int unsigned AW = 8;
   // register byte offsets
   localparam logic [AW-1:0] OFS_CTRL   = 8'h00;
   localparam logic [AW-1:0] OFS_NINTH  = 8'h04;
   localparam logic [AW-1:0] OFS_STAT1  = 8'h08;
   localparam logic [AW-1:0] OFS_STAT2  = 8'h0c;
   localparam logic [AW-1:0] OFS_DATA   = 8'h18;
   // control register fields
   localparam int unsigned CT_ENABLE  = 0;
   localparam int unsigned CT_NINE    = 1;
   localparam int unsigned CT_RXEN    = 2;
   localparam int unsigned CT_TEIE    = 4;
   localparam int unsigned CT_TX_COMPLETE_IRQ_EN    = 5;
   localparam int unsigned CT_RFIE    = 6;
   localparam int unsigned CT_IDLE_IRQ_EN    = 7;
   // ninth bit and error enable register fields
   localparam int unsigned NB_RX8     = 7;
   localparam int unsigned NB_TX8     = 6;
   localparam int unsigned NB_OVERRUN_IRQ_EN    = 3;
   localparam int unsigned NB_NOISE_IRQ_EN    = 2;
   localparam int unsigned NB_FRAMING_IRQ_EN    = 1;
   localparam int unsigned NB_PARITY_IRQ_EN    = 0;
   // primary status fields
   localparam int unsigned S1_TE      = 7;
   localparam int unsigned S1_TC      = 6;
   localparam int unsigned S1_RF      = 5;
   localparam int unsigned S1_IDLE    = 4;
   localparam int unsigned S1_OR      = 3;
   localparam int unsigned S1_NF      = 2;
   localparam int unsigned S1_FE      = 1;
   localparam int unsigned S1_PE      = 0;
   // secondary status fields
   localparam int unsigned S2_BKF     = 1;
   localparam int unsigned S2_RPF     = 0;
   // reset values
   localparam logic [7:0] CTRL_RST    = 8'h00;
   localparam logic [3:0] ERRIE_RST   = 4'h0;
   // idle run length in bit times for 8-bit and 9-bit characters
   localparam logic [3:0] IDLE_BITS8  = 4'ha;
   localparam logic [3:0] IDLE_BITS9  = 4'hb;
   // axi response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : assd_pkg

// ===== testbench/assd_far_model.sv
// remote serial partner: receive events and a transmit shifter
`timescale 1ns/1ns
`default_nettype none
module assd_far_model (
   input  wire logic       mclk_i,
   input  wire logic       stall_i,
   input  wire logic       tx_load_i,
   input  wire logic [8:0] tx_word_i,
   output logic            rxd_o,
   output logic            bit_tick_o,
   output logic            rx_done_o,
   output logic [8:0]      rx_word_o,
   output logic [2:0]      rx_err_o,
   output logic [2:0]      rx_evt_o,
   output logic            tx_ready_o,
   output logic            tx_busy_o,
   output logic [8:0]      tx_seen_o
);
   int unsigned busy_cnt = 0;
   // line idles high; qualifiers carry the inverted last value outside a pulse
   initial begin
      rxd_o = 1'b1;
      bit_tick_o = 1'b0;
      rx_done_o = 1'b0;
      rx_word_o = 9'h000;
      rx_err_o = 3'h0;
      rx_evt_o = 3'h0;
   end
   // one character: line low, then a one-cycle completion pulse
   task automatic rx_char(input logic [8:0] w, input logic [2:0] e);
      @(posedge mclk_i);
      rxd_o <= 1'b0;
      repeat (3) @(posedge mclk_i);
      rx_done_o <= 1'b1;
      rx_word_o <= w;
      rx_err_o <= e;
      @(posedge mclk_i);
      rx_done_o <= 1'b0;
      rx_word_o <= ~w;
      rx_err_o <= ~e;
      rxd_o <= 1'b1;
      @(posedge mclk_i);
   endtask : rx_char
   // event pulse: break, first-slot zero, false start
   task automatic strobe(input logic [2:0] k);
      @(posedge mclk_i);
      rx_evt_o <= k;
      @(posedge mclk_i);
      rx_evt_o <= 3'h0;
      @(posedge mclk_i);
   endtask : strobe
   task automatic set_line(input logic v);
      @(posedge mclk_i);
      rxd_o <= v;
   endtask : set_line
   // bit-time pulses, line left where it is
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge mclk_i);
         bit_tick_o <= 1'b1;
         @(posedge mclk_i);
         bit_tick_o <= 1'b0;
      end
   endtask : ticks
   // shifter stays busy a fixed span after each load, so empty and complete part
   always_ff @(posedge mclk_i) begin
      if (tx_load_i) begin
         tx_seen_o <= tx_word_i;
         busy_cnt <= 20;
      end else if (busy_cnt != 0) begin
         busy_cnt <= busy_cnt - 1;
      end
   end
   assign tx_busy_o = (busy_cnt != 0);
   assign tx_ready_o = !stall_i && (busy_cnt == 0);
endmodule : assd_far_model
`default_nettype wire

// ===== testbench/tb.sv
// self-checking bench for the serial status block
`timescale 1ns/1ns
`default_nettype none
module tb;
   import assd_pkg::*;
   logic        mclk = 1'b0;
   logic        rstn = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        stall = 1'b0;
   logic [3:0]  wstrb = 4'h1;
   logic        awready, wready, bvalid, arready, rvalid, rxd, tick, done, txrdy, txbusy, txload;
   logic        txirq, rxirq, errirq;
   logic [1:0]  bresp, rresp, rsp;
   logic [31:0] rdata, rdat;
   logic [8:0]  word, txword, seen;
   logic [2:0]  err, evt;
   int          mismatches = 0;
   int          samples_checked = 0;
   assd_core assd_core_inst (
      .mclk_i(mclk), .rstn_i(rstn), .s_awaddr_i(awaddr), .s_awvalid_i(awvalid),
      .s_awready_o(awready), .s_wdata_i(wdata), .s_wstrb_i(wstrb), .s_wvalid_i(wvalid),
      .s_wready_o(wready), .s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready),
      .s_araddr_i(araddr), .s_arvalid_i(arvalid), .s_arready_o(arready), .s_rdata_o(rdata),
      .s_rresp_o(rresp), .s_rvalid_o(rvalid), .s_rready_i(rready), .rxd_i(rxd),
      .bit_tick_i(tick), .rx_done_i(done), .rx_word_i(word), .rx_noise_i(err[2]),
      .rx_frame_i(err[1]), .rx_parity_i(err[0]), .rx_break_i(evt[2]),
      .rx_slot_zero_i(evt[1]), .rx_false_start_i(evt[0]), .tx_ready_i(txrdy),
      .tx_busy_i(txbusy), .tx_load_o(txload), .tx_word_o(txword), .tx_irq_o(txirq),
      .rx_irq_o(rxirq), .err_irq_o(errirq));
   assd_far_model assd_far_model_inst (
      .mclk_i(mclk), .stall_i(stall), .tx_load_i(txload), .tx_word_i(txword), .rxd_o(rxd),
      .bit_tick_o(tick), .rx_done_o(done), .rx_word_o(word), .rx_err_o(err), .rx_evt_o(evt),
      .tx_ready_o(txrdy), .tx_busy_o(txbusy), .tx_seen_o(seen));
   // 250 MHz clock
   always #2 mclk = ~mclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // one register access; each channel held until its own handshake edge
   task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      if (we) begin
         awaddr <= a;
         wdata <= {24'h0, d};
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         do @(posedge mclk); while ((awready & wready) !== 1'b1);
         awvalid <= 1'b0;
         wvalid <= 1'b0;
         do @(posedge mclk); while (bvalid !== 1'b1);
         rsp = bresp;
         bready <= 1'b0;
      end else begin
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         do @(posedge mclk); while (arready !== 1'b1);
         arvalid <= 1'b0;
         do @(posedge mclk); while (rvalid !== 1'b1);
         rdat = rdata;
         rsp = rresp;
         rready <= 1'b0;
      end
   endtask : xfer
   task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      xfer(1'b0, a, 8'h00);
      chk(rdat & {24'h0, m}, {24'h0, e});
   endtask : rchk
   task automatic rxc(input logic [8:0] w, input logic [2:0] e);
      assd_far_model_inst.rx_char(w, e);
   endtask : rxc
   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : final_report
   // reset values, unused addresses answer with an error
   task automatic t_reset;
      rchk(OFS_STAT1, 8'hff, 8'hc0);
      rchk(OFS_STAT2, 8'hff, 8'h00);
      wstrb <= 4'h0;
      xfer(1'b1, OFS_NINTH, 8'h0f);
      wstrb <= 4'h1;
      chk({30'h0, rsp}, {30'h0, RESP_OKAY});
      rchk(OFS_NINTH, 8'h0f, 8'h00);
      xfer(1'b0, 8'h10, 8'h00);
      chk({rdat[29:0], rsp}, {30'h0, RESP_SLVERR});
      xfer(1'b1, 8'h14, 8'h00);
      chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
      $display("reset test done");
   endtask : t_reset
   // received ninth bit in both lengths; buffer survives a reset
   task automatic t_rx;
      logic [8:0] w;
      xfer(1'b1, OFS_CTRL, 8'h47);
      rxc(9'h1a5, 3'h0);
      chk({31'h0, rxirq}, 32'h1);
      rchk(OFS_STAT1, 8'h3f, 8'h20);
      rchk(OFS_NINTH, 8'h80, 8'h80);
      rchk(OFS_DATA, 8'hff, 8'ha5);
      rchk(OFS_STAT1, 8'h3f, 8'h00);
      xfer(1'b1, OFS_CTRL, 8'h45);
      for (int i = 0; i < 2; i++) begin
         w = (i == 0) ? 9'h17f : 9'h080;
         rxc(w, 3'h0);
         rchk(OFS_STAT1, 8'h20, 8'h20);
         rchk(OFS_NINTH, 8'h80, {w[7], 7'h0});
         rchk(OFS_DATA, 8'hff, w[7:0]);
      end
      rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      rchk(OFS_DATA, 8'hff, 8'h80);
      rchk(OFS_NINTH, 8'h80, 8'h80);
      $display("rx test done");
   endtask : t_rx
   // overrun keeps the old byte; late overrun survives the clear
   task automatic t_ovr;
      xfer(1'b1, OFS_CTRL, 8'h45);
      xfer(1'b1, OFS_NINTH, 8'h08);
      rxc(9'h011, 3'h0);
      rxc(9'h022, 3'h0);
      rchk(OFS_STAT1, 8'h3f, 8'h28);
      chk({31'h0, errirq}, 32'h1);
      rchk(OFS_DATA, 8'hff, 8'h11);
      rchk(OFS_STAT1, 8'h3f, 8'h00);
      rxc(9'h033, 3'h0);
      rchk(OFS_STAT1, 8'h3f, 8'h20);
      rxc(9'h044, 3'h0);
      rchk(OFS_DATA, 8'hff, 8'h33);
      rchk(OFS_STAT1, 8'h3f, 8'h08);
      rchk(OFS_DATA, 8'hff, 8'h33);
      rchk(OFS_STAT1, 8'h3f, 8'h00);
      $display("overrun test done");
   endtask : t_ovr
   // noise, framing and parity, each gated by its own enable
   task automatic t_err;
      logic [7:0] b;
      xfer(1'b1, OFS_NINTH, 8'h00);
      for (int i = 0; i < 3; i++) begin
         b = 8'h04 >> i;
         rxc(9'h055, b[2:0]);
         chk({31'h0, errirq}, 32'h0);
         xfer(1'b1, OFS_NINTH, b);
         chk({31'h0, errirq}, 32'h1);
         rchk(OFS_STAT1, 8'h3f, 8'h20 | b);
         rchk(OFS_DATA, 8'hff, 8'h55);
         chk({31'h0, errirq}, 32'h0);
      end
      $display("error test done");
   endtask : t_err
   // idle after 10 or 11 bit times, only once armed by a character
   task automatic t_idle;
      xfer(1'b1, OFS_NINTH, 8'h00);
      xfer(1'b1, OFS_CTRL, 8'hc5);
      assd_far_model_inst.ticks(9);
      rchk(OFS_STAT1, 8'h10, 8'h00);
      assd_far_model_inst.ticks(1);
      rchk(OFS_STAT1, 8'h10, 8'h10);
      chk({31'h0, errirq}, 32'h1);
      xfer(1'b0, OFS_DATA, 8'h00);
      assd_far_model_inst.ticks(12);
      rchk(OFS_STAT1, 8'h10, 8'h00);
      xfer(1'b1, OFS_CTRL, 8'hc7);
      rxc(9'h000, 3'h0);
      xfer(1'b0, OFS_STAT1, 8'h00);
      xfer(1'b0, OFS_DATA, 8'h00);
      assd_far_model_inst.ticks(10);
      rchk(OFS_STAT1, 8'h10, 8'h00);
      assd_far_model_inst.ticks(1);
      rchk(OFS_STAT1, 8'h10, 8'h10);
      xfer(1'b0, OFS_DATA, 8'h00);
      $display("idle test done");
   endtask : t_idle
   // break flags, clear sequence, no rearm while the line stays low
   task automatic t_brk;
      xfer(1'b1, OFS_CTRL, 8'h47);
      rxc(9'h1ff, 3'h0);
      xfer(1'b0, OFS_STAT1, 8'h00);
      xfer(1'b0, OFS_DATA, 8'h00);
      assd_far_model_inst.set_line(1'b0);
      assd_far_model_inst.strobe(3'h4);
      rchk(OFS_STAT1, 8'h3f, 8'h22);
      rchk(OFS_NINTH, 8'h80, 8'h00);
      rchk(OFS_STAT2, 8'h02, 8'h02);
      rchk(OFS_DATA, 8'hff, 8'h00);
      rchk(OFS_STAT2, 8'h02, 8'h00);
      rchk(OFS_STAT1, 8'h3f, 8'h00);
      assd_far_model_inst.strobe(3'h4);
      rchk(OFS_STAT2, 8'h02, 8'h00);
      assd_far_model_inst.set_line(1'b1);
      assd_far_model_inst.ticks(2);
      assd_far_model_inst.strobe(3'h4);
      rchk(OFS_STAT2, 8'h02, 8'h02);
      xfer(1'b0, OFS_STAT1, 8'h00);
      xfer(1'b0, OFS_DATA, 8'h00);
      $display("break test done");
   endtask : t_brk
   // reception flag follows first-slot zero and false start
   task automatic t_rpf;
      assd_far_model_inst.strobe(3'h1);
      rchk(OFS_STAT2, 8'h01, 8'h00);
      assd_far_model_inst.strobe(3'h2);
      rchk(OFS_STAT2, 8'h01, 8'h01);
      assd_far_model_inst.strobe(3'h1);
      rchk(OFS_STAT2, 8'h01, 8'h00);
      $display("reception test done");
   endtask : t_rpf
   // transmit path with stalled shifter, then disable forces both flags
   task automatic t_tx;
      stall <= 1'b1;
      xfer(1'b1, OFS_CTRL, 8'h13);
      chk({31'h0, txirq}, 32'h1);
      xfer(1'b1, OFS_NINTH, 8'h40);
      rchk(OFS_STAT1, 8'hc0, 8'hc0);
      xfer(1'b1, OFS_DATA, 8'h5a);
      rchk(OFS_STAT1, 8'hc0, 8'h00);
      chk({31'h0, txirq}, 32'h0);
      stall <= 1'b0;
      do @(posedge mclk); while (txbusy !== 1'b1);
      chk({23'h0, seen}, 32'h15a);
      rchk(OFS_STAT1, 8'hc0, 8'h80);
      do @(posedge mclk); while (txbusy !== 1'b0);
      rchk(OFS_STAT1, 8'hc0, 8'hc0);
      stall <= 1'b1;
      xfer(1'b0, OFS_STAT1, 8'h00);
      xfer(1'b1, OFS_DATA, 8'h3c);
      rchk(OFS_STAT1, 8'hc0, 8'h00);
      xfer(1'b1, OFS_CTRL, 8'h00);
      rchk(OFS_STAT1, 8'hc0, 8'hc0);
      $display("tx test done");
   endtask : t_tx
   // main sequence
   initial begin
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      t_reset;
      t_rx;
      t_ovr;
      t_err;
      t_idle;
      t_brk;
      t_rpf;
      t_tx;
      final_report;
   end
   // watchdog well beyond the several hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      final_report;
   end
endmodule : tb
`default_nettype wire
